// File: dac_host_pkg.sv
// Shared constants and carrier types for the converter host interface
package dac_host_pkg;

    localparam int CHANNELS = 40;
    localparam int CH_W = 6;
    localparam int WORD_W = 14;

    // Register class encodings on the class-select pair
    localparam logic [1:0] CLASS_SFR = 2'h0;
    localparam logic [1:0] CLASS_GAIN = 2'h1;
    localparam logic [1:0] CLASS_OFFSET = 2'h2;
    localparam logic [1:0] CLASS_DATA = 2'h3;

    // Reset values of the per-channel registers and the clear code
    localparam logic [13:0] DATA_RST = 14'h2000;
    localparam logic [13:0] GAIN_RST = 14'h3FFE;
    localparam logic [13:0] OFFSET_RST = 14'h2000;
    localparam logic [13:0] CLEAR_CODE_RST = 14'h2000;

    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CLEAR_TIME_NS = 35_000;
    localparam int CLEAR_CYCLES = (CLEAR_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int RESET_TIME_NS = 270_000;
    localparam int RESET_CYCLES = (RESET_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    // One cycle per channel to compute the final value
    localparam int CALC_CYCLES = CHANNELS;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic [CH_W-1:0] channel;
        logic [1:0] reg_class;
        logic [WORD_W-1:0] word;
        logic ab_sel;
    } par_write_t;

    typedef struct packed {
        logic [CH_W-1:0] channel;
        logic [WORD_W-1:0] value;
    } dac_update_t;

endpackage

// File: dac_host_interface_control.sv
// Host port decode, toggle A/B data, busy sequencing and serial output timing
`timescale 1ns/1ps
// Summary of operation
// - Write taken on strobe rise with select low
// - Serial select plus chain input gives chaining
// - Two address pins form the bus address
// - Top data line is most significant bit
// - Six channel lines select one of 40
// - Class lines pick data, offset, gain, special
// - Serial out three-state, shift on rising edge
// - Toggle mode: A/B input picks data register
// - In toggle mode each load pulse swaps A and B output
// - Normal mode writes go to register A
// - Busy low while computing final value
// - Writes accepted while busy in calculation or clear (not reset), updates blocked
// - Load request during calculation is remembered
// - During reset busy low, interface off
// - Clear also drives busy low
// - Select pin high serial, low parallel
// - Chip select level sensitive, active low
// - Clear loads clear code, busy 35 us
module dac_host_interface_control
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic interface_select_i,
    input wire logic chip_select_n_i,
    input wire logic write_strobe_i,
    input wire logic chain_mode_select_i,
    input wire logic bus_address_pin_low_i,
    input wire logic bus_address_pin_high_i,
    input wire logic [13:0] parallel_word_lines_i,
    input wire logic [5:0] channel_select_lines_i,
    input wire logic [1:0] register_class_select_i,
    input wire logic ab_select_i,
    input wire logic toggle_mode_i,
    input wire logic load_outputs_n_i,
    input wire logic clear_input_n_i,
    input wire logic reset_input_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_bit_i,
    output logic busy_n_o,
    output logic daisy_chain_o,
    output logic serial_mode_o,
    output logic [1:0] bus_address_o,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic dac_update_valid_o,
    output dac_host_pkg::dac_update_t dac_update_o,
    output logic [13:0] special_word_o,
    output logic special_valid_o
);

    typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_CALC, ST_CLEAR} busy_st_t;

    // ========================================================
    // Input synchronisers, two stages for every pin
    // ========================================================
    localparam int SYN_W = 35;
    logic [SYN_W-1:0] pin_raw, syn1_r, syn2_r, prev_r;
    assign pin_raw = {interface_select_i, chip_select_n_i, write_strobe_i,
        chain_mode_select_i, bus_address_pin_low_i, bus_address_pin_high_i,
        parallel_word_lines_i, channel_select_lines_i,
        register_class_select_i, ab_select_i, toggle_mode_i,
        load_outputs_n_i, clear_input_n_i, reset_input_n_i,
        serial_clock_i, serial_bit_i};

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            syn1_r <= '0;
            syn2_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            syn1_r <= pin_raw;
            syn2_r <= syn1_r;
            prev_r <= syn2_r;
        end
    end

    logic s_ser, s_cs_n, s_wr, s_chain, s_ad0, s_ad1, s_ab, s_tog;
    logic [13:0] s_word;
    logic [5:0] s_ch;
    logic [1:0] s_cls;
    assign {s_ser, s_cs_n, s_wr, s_chain, s_ad0, s_ad1, s_word, s_ch, s_cls,
        s_ab, s_tog} = syn2_r[SYN_W-1:5];
    logic wr_rise, ld_fall, clr_fall, rst_fall, sclk_rise;
    assign wr_rise = s_wr & ~prev_r[32];
    assign ld_fall = ~syn2_r[4] & prev_r[4];
    assign clr_fall = ~syn2_r[3] & prev_r[3];
    assign rst_fall = ~syn2_r[2] & prev_r[2];
    assign sclk_rise = syn2_r[1] & ~prev_r[1];

    // ========================================================
    // Channel register storage
    // ========================================================
    logic [13:0] data_a_r [dac_host_pkg::CHANNELS];
    logic [13:0] data_b_r [dac_host_pkg::CHANNELS];
    logic [13:0] gain_r [dac_host_pkg::CHANNELS];
    logic [13:0] offset_r [dac_host_pkg::CHANNELS];
    logic [dac_host_pkg::CHANNELS-1:0] use_b_r, use_b_nxt;
    logic [13:0] clear_code_r;

    logic busy_n_r, busy_n_nxt;
    busy_st_t st_r, st_nxt;
    dac_host_pkg::par_write_t wr;
    logic wr_ok;
    assign wr = '{channel: s_ch, reg_class: s_cls, word: s_word, ab_sel: s_ab};
    // Interface dead during reset; writes still land during calculation
    assign wr_ok = wr_rise && !s_cs_n && !s_ser && st_r != ST_RESET &&
        wr.channel < 6'(dac_host_pkg::CHANNELS);

    genvar gi;
    generate
        for (gi = 0; gi < dac_host_pkg::CHANNELS; gi++)
        begin : g_ch
            logic hit;
            assign hit = wr_ok && wr.channel == 6'(gi);
            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    data_a_r[gi] <= dac_host_pkg::DATA_RST;
                    data_b_r[gi] <= dac_host_pkg::DATA_RST;
                    gain_r[gi] <= dac_host_pkg::GAIN_RST;
                    offset_r[gi] <= dac_host_pkg::OFFSET_RST;
                end
                else if (st_r == ST_RESET)
                begin
                    data_a_r[gi] <= dac_host_pkg::DATA_RST;
                    data_b_r[gi] <= dac_host_pkg::DATA_RST;
                    gain_r[gi] <= dac_host_pkg::GAIN_RST;
                    offset_r[gi] <= dac_host_pkg::OFFSET_RST;
                end
                else if (hit)
                begin
                    unique case (wr.reg_class)
                        dac_host_pkg::CLASS_DATA:
                        begin
                            if (s_tog && wr.ab_sel)
                                data_b_r[gi] <= wr.word;
                            else
                                data_a_r[gi] <= wr.word;
                        end
                        dac_host_pkg::CLASS_OFFSET:
                            offset_r[gi] <= wr.word;
                        dac_host_pkg::CLASS_GAIN:
                            gain_r[gi] <= wr.word;
                        dac_host_pkg::CLASS_SFR:
                        begin
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Special function writes: channel 0 carries the clear code
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            clear_code_r <= dac_host_pkg::CLEAR_CODE_RST;
        else if (wr_ok && wr.reg_class == dac_host_pkg::CLASS_SFR &&
            wr.channel == 6'h00)
            clear_code_r <= wr.word;
    end

    // ========================================================
    // Busy sequencer: calculation, clear and reset
    // ========================================================
    logic [15:0] cnt_r, cnt_nxt;
    logic pend_r, pend_nxt;
    logic upd_v_r, upd_v_nxt, sfr_v_r, sfr_v_nxt;
    dac_host_pkg::dac_update_t upd_r, upd_nxt;
    logic [5:0] idx;
    logic [14:0] prod;
    logic [13:0] src;
    assign idx = cnt_r[5:0];
    assign src = use_b_r[idx] ? data_b_r[idx] : data_a_r[idx];
    // Simplified final value: gain scaled input plus signed offset
    assign prod = 15'((29'(src) * 29'(gain_r[idx])) >> 14) +
        15'(offset_r[idx]) - 15'h2000;

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        busy_n_nxt = busy_n_r;
        use_b_nxt = use_b_r;
        upd_v_nxt = 1'b0;
        upd_nxt = upd_r;
        sfr_v_nxt = wr_ok && wr.reg_class == dac_host_pkg::CLASS_SFR;
        if (rst_fall)
        begin
            st_nxt = ST_RESET;
            cnt_nxt = '0;
            pend_nxt = 1'b0;
            busy_n_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                ST_RESET:
                begin
                    busy_n_nxt = 1'b0;
                    cnt_nxt = cnt_r + 16'h0001;
                    use_b_nxt = '0;
                    if (cnt_r == 16'(dac_host_pkg::RESET_CYCLES - 1))
                    begin
                        st_nxt = ST_IDLE;
                        busy_n_nxt = 1'b1;
                    end
                end
                ST_IDLE:
                begin
                    busy_n_nxt = 1'b1;
                    cnt_nxt = '0;
                    if (clr_fall)
                    begin
                        st_nxt = ST_CLEAR;
                        busy_n_nxt = 1'b0;
                    end
                    else if (ld_fall || pend_r)
                    begin
                        if (s_tog)
                            use_b_nxt = ~use_b_r;
                        pend_nxt = 1'b0;
                        st_nxt = ST_CALC;
                        busy_n_nxt = 1'b0;
                    end
                end
                ST_CALC:
                begin
                    if (ld_fall)
                        pend_nxt = 1'b1;
                    upd_v_nxt = 1'b1;
                    upd_nxt = '{channel: idx, value: prod[13:0]};
                    cnt_nxt = cnt_r + 16'h0001;
                    if (cnt_r == 16'(dac_host_pkg::CALC_CYCLES - 1))
                    begin
                        st_nxt = ST_IDLE;
                        busy_n_nxt = !pend_nxt;
                    end
                end
                ST_CLEAR:
                begin
                    if (ld_fall)
                        pend_nxt = 1'b1;
                    if (cnt_r < 16'(dac_host_pkg::CHANNELS))
                    begin
                        upd_v_nxt = 1'b1;
                        upd_nxt = '{channel: idx, value: clear_code_r};
                    end
                    cnt_nxt = cnt_r + 16'h0001;
                    if (cnt_r == 16'(dac_host_pkg::CLEAR_CYCLES - 1))
                    begin
                        st_nxt = ST_IDLE;
                        busy_n_nxt = !pend_nxt;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= ST_RESET;
            cnt_r <= '0;
            pend_r <= 1'b0;
            busy_n_r <= 1'b0;
            use_b_r <= '0;
            upd_v_r <= 1'b0;
            upd_r <= '0;
            sfr_v_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            busy_n_r <= busy_n_nxt;
            use_b_r <= use_b_nxt;
            upd_v_r <= upd_v_nxt;
            upd_r <= upd_nxt;
            sfr_v_r <= sfr_v_nxt;
        end
    end

    // ========================================================
    // Serial mode status and output shifting
    // ========================================================
    logic daisy_r, ser_r, so_r, soe_r, so_nxt, soe_nxt;
    logic [1:0] addr_r;
    logic [13:0] sfr_r;
    logic [23:0] shift_r, shift_nxt;

    always_comb
    begin
        shift_nxt = shift_r;
        so_nxt = so_r;
        soe_nxt = s_ser && !s_cs_n;
        if (sclk_rise && soe_nxt)
        begin
            // Rising edge shifts out so the receiver samples on the fall
            so_nxt = shift_r[23];
            shift_nxt = {shift_r[22:0], syn2_r[0]};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            daisy_r <= 1'b0;
            ser_r <= 1'b0;
            addr_r <= 2'h0;
            shift_r <= '0;
            so_r <= 1'b0;
            soe_r <= 1'b0;
            sfr_r <= '0;
        end
        else
        begin
            ser_r <= s_ser;
            daisy_r <= s_ser && s_chain;
            addr_r <= {s_ad1, s_ad0};
            shift_r <= shift_nxt;
            so_r <= so_nxt;
            soe_r <= soe_nxt && daisy_r;
            sfr_r <= sfr_v_nxt ? wr.word : sfr_r;
        end
    end

    assign busy_n_o = busy_n_r;
    assign daisy_chain_o = daisy_r;
    assign serial_mode_o = ser_r;
    assign bus_address_o = addr_r;
    assign serial_out_o = so_r;
    assign serial_out_oe_o = soe_r;
    assign dac_update_valid_o = upd_v_r;
    assign dac_update_o = upd_r;
    assign special_word_o = sfr_r;
    assign special_valid_o = sfr_v_r;

endmodule

// File: dac_host_interface_control_properties.sv
// Checker of busy, mode and update timing at the host port
`timescale 1ns/1ps
module dac_host_interface_control_properties
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic interface_select_i,
    input wire logic chip_select_n_i,
    input wire logic chain_mode_select_i,
    input wire logic bus_address_pin_low_i,
    input wire logic bus_address_pin_high_i,
    input wire logic load_outputs_n_i,
    input wire logic clear_input_n_i,
    input wire logic busy_n_o,
    input wire logic daisy_chain_o,
    input wire logic serial_mode_o,
    input wire logic [1:0] bus_address_o,
    input wire logic serial_out_oe_o,
    input wire logic dac_update_valid_o,
    input wire dac_host_pkg::dac_update_t dac_update_o
);
    logic [15:0] low_cnt_r;
    logic [15:0] low_cnt_nxt;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // Busy-low run length
    always_comb
    begin
        low_cnt_nxt = busy_n_o ? 16'h0000 : low_cnt_r + 16'h0001;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            low_cnt_r <= 16'h0000;
        else
            low_cnt_r <= low_cnt_nxt;
    end
    // ==========================================================
    // Properties
    // Pins must settle past the synchronisers before outputs follow
    sequence s_pins_steady;
        ($stable({interface_select_i, chip_select_n_i, chain_mode_select_i,
            bus_address_pin_low_i, bus_address_pin_high_i}))[*6];
    endsequence
    sequence s_idle_fall(sig);
        busy_n_o && $fell(sig);
    endsequence
    property p_busy_in_reset;
        $rose(rst_n_i) |-> (!busy_n_o)[*8];
    endproperty
    property p_update_in_busy;
        dac_update_valid_o |-> !busy_n_o || !$past(busy_n_o);
    endproperty
    property p_channel_range;
        dac_update_valid_o |-> dac_update_o.channel < dac_host_pkg::CHANNELS;
    endproperty
    property p_modes;
        s_pins_steady |-> serial_mode_o == interface_select_i
            && daisy_chain_o == (interface_select_i && chain_mode_select_i)
            && bus_address_o == {bus_address_pin_high_i, bus_address_pin_low_i};
    endproperty
    property p_oe;
        s_pins_steady |-> serial_out_oe_o == (interface_select_i
            && !chip_select_n_i && chain_mode_select_i);
    endproperty
    property p_load_busy;
        s_idle_fall(load_outputs_n_i) |-> ##[1:6] !busy_n_o;
    endproperty
    property p_clear_busy;
        s_idle_fall(clear_input_n_i) |-> ##[1:6] !busy_n_o;
    endproperty
    property p_busy_min;
        $rose(busy_n_o) |-> low_cnt_r >= 16'h0028;
    endproperty
    a_busy_in_reset: assert property (p_busy_in_reset)
        else $error("busy high right after reset");
    a_update_in_busy: assert property (p_update_in_busy)
        else $error("update outside busy");
    a_channel_range: assert property (p_channel_range)
        else $error("update channel out of range");
    a_modes: assert property (p_modes)
        else $error("mode or address outputs wrong");
    a_oe: assert property (p_oe)
        else $error("serial output enable wrong");
    a_load_busy: assert property (p_load_busy)
        else $error("load did not start busy");
    a_clear_busy: assert property (p_clear_busy)
        else $error("clear did not start busy");
    a_busy_min: assert property (p_busy_min)
        else $error("busy run too short");
endmodule
bind dac_host_interface_control dac_host_interface_control_properties chk_u
(
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .interface_select_i(interface_select_i),
    .chip_select_n_i(chip_select_n_i),
    .chain_mode_select_i(chain_mode_select_i),
    .bus_address_pin_low_i(bus_address_pin_low_i),
    .bus_address_pin_high_i(bus_address_pin_high_i),
    .load_outputs_n_i(load_outputs_n_i), .clear_input_n_i(clear_input_n_i),
    .busy_n_o(busy_n_o), .daisy_chain_o(daisy_chain_o),
    .serial_mode_o(serial_mode_o), .bus_address_o(bus_address_o),
    .serial_out_oe_o(serial_out_oe_o),
    .dac_update_valid_o(dac_update_valid_o), .dac_update_o(dac_update_o)
);

// File: host_serial_model.sv
// Host serial model: framed clock, data out, readback capture
`timescale 1ns/1ps
module host_serial_model
(
    input wire logic clk_sys_i,
    input wire logic frame_i,
    input wire logic serial_data_i,
    output logic serial_clock_o,
    output logic serial_bit_o,
    output logic [4:0] rx_count_o,
    output logic [15:0] rx_data_o
);
    logic [15:0] rx_r;
    assign rx_data_o = rx_r;
    initial
    begin
        serial_clock_o = 1'b0;
        serial_bit_o = 1'b0;
        rx_count_o = 5'h00;
        rx_r = 16'h0000;
    end
    // Clock stands low between frames; half periods of four system
    // clocks so the pin synchronisers see every edge
    always @(posedge frame_i)
    begin
        rx_count_o <= 5'h00;
        repeat (16)
        begin
            repeat (4) @(posedge clk_sys_i);
            serial_clock_o <= 1'b1;
            serial_bit_o <= ~serial_bit_o;
            repeat (4) @(posedge clk_sys_i);
            serial_clock_o <= 1'b0;
            rx_r <= {rx_r[14:0], serial_data_i};
            rx_count_o <= rx_count_o + 5'h01;
        end
    end
endmodule

// File: dac_host_interface_control_tb_top.sv
// Self-checking bench of the converter host interface
`timescale 1ns/1ps
module dac_host_interface_control_tb_top;
    logic clk, rst_n, sel, cs_n, wr, chain, adl, adh, ab, tog, frame;
    logic ld_n, clr_n, rs_n, sclk, sbit, sdo, oe, busy_n, upd_v;
    logic daisy, smode, spec_v;
    logic [1:0] baddr, cls;
    logic [4:0] rx_cnt;
    logic [15:0] rx_dat;
    logic [5:0] chan;
    logic [13:0] word, spec_word, spec_w, va;
    logic [13:0] seen [0:63];
    dac_host_pkg::dac_update_t upd;
    int n_errors = 0, samples_checked = 0, n_upd = 0, n_low = 0, cyc = 0;
    dac_host_interface_control dut_u (.clk_sys_i(clk), .rst_n_i(rst_n),
        .interface_select_i(sel), .chip_select_n_i(cs_n),
        .write_strobe_i(wr), .chain_mode_select_i(chain),
        .bus_address_pin_low_i(adl), .bus_address_pin_high_i(adh),
        .parallel_word_lines_i(word), .channel_select_lines_i(chan),
        .register_class_select_i(cls), .ab_select_i(ab),
        .toggle_mode_i(tog), .load_outputs_n_i(ld_n),
        .clear_input_n_i(clr_n), .reset_input_n_i(rs_n),
        .serial_clock_i(sclk), .serial_bit_i(sbit), .busy_n_o(busy_n),
        .daisy_chain_o(daisy), .serial_mode_o(smode),
        .bus_address_o(baddr), .serial_out_o(sdo), .serial_out_oe_o(oe),
        .dac_update_valid_o(upd_v), .dac_update_o(upd),
        .special_word_o(spec_word), .special_valid_o(spec_v));
    host_serial_model host_u (.clk_sys_i(clk), .frame_i(frame),
        .serial_data_i(sdo), .serial_clock_o(sclk), .serial_bit_o(sbit),
        .rx_count_o(rx_cnt), .rx_data_o(rx_dat));
    always #20 clk = ~clk;
    // ==========================================================
    // Tasks
    function automatic logic [13:0] calc(input logic [13:0] w,
        input logic [13:0] g = dac_host_pkg::GAIN_RST,
        input logic [13:0] o = dac_host_pkg::OFFSET_RST);
        logic [27:0] p;
        p = w * g;
        return p[27:14] + o - 14'h2000;
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_par(input logic [5:0] c, input logic [1:0] k,
        input logic [13:0] w, input logic b);
        chan <= c;
        cls <= k;
        word <= w;
        ab <= b;
        tick(3);
        wr <= 1'b1;
        tick(4);
        wr <= 1'b0;
        tick(3);
    endtask
    // Strobe low for four clocks: 0 load, 1 clear, 2 reset
    task automatic pulse_low(input int k);
        if (k == 0)
            ld_n <= 1'b0;
        else if (k == 1)
            clr_n <= 1'b0;
        else
            rs_n <= 1'b0;
        tick(4);
        {ld_n, clr_n, rs_n} <= 3'h7;
    endtask
    // Hangs here are cut short by the cycle ceiling
    task automatic wait_idle;
        tick(2);
        while (busy_n !== 1'b1)
            tick(1);
        // One more edge so the monitor has logged the last update
        tick(1);
    endtask
    // ==========================================================
    // Monitor and cycle ceiling
    always @(posedge clk)
    begin
        if (upd_v === 1'b1)
        begin
            seen[upd.channel] = upd.value;
            n_upd++;
        end
        if (busy_n === 1'b0)
            n_low++;
        if (spec_v === 1'b1)
            spec_w = spec_word;
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    // ==========================================================
    // Sequence
    initial
    begin
        {clk, rst_n, sel, cs_n, wr, chain, adl, adh, ab, tog, frame} = '0;
        {ld_n, clr_n, rs_n} = 3'h7;
        {word, chan, cls} = '0;
        foreach (seen[i]) seen[i] = 14'h0000;
        tick(20);
        rst_n <= 1'b1;
        tick(2);
        check(busy_n, 1'b0);
        wait_idle();
        for (int i = 0; i < 16; i++)
        begin
            {sel, chain, adh, adl} <= i[3:0];
            tick(6);
            check({smode, daisy, baddr}, {i[3], i[3] & i[2], i[1:0]});
        end
        {sel, chain, adh, adl} <= 4'h0;
        tick(4);
        wr_par(6'h05, dac_host_pkg::CLASS_DATA, 14'h2A55, 1'b0);
        wr_par(6'h06, dac_host_pkg::CLASS_OFFSET, 14'h2100, 1'b0);
        wr_par(6'h06, dac_host_pkg::CLASS_DATA, 14'h0400, 1'b1);
        wr_par(6'h07, dac_host_pkg::CLASS_GAIN, 14'h2000, 1'b0);
        wr_par(6'h00, dac_host_pkg::CLASS_SFR, 14'h1234, 1'b0);
        check(spec_w, 14'h1234);
        cs_n <= 1'b1;
        wr_par(6'h05, dac_host_pkg::CLASS_DATA, 14'h0111, 1'b0);
        cs_n <= 1'b0;
        sel <= 1'b1;
        wr_par(6'h05, dac_host_pkg::CLASS_DATA, 14'h0222, 1'b0);
        sel <= 1'b0;
        tick(4);
        n_upd = 0;
        pulse_low(0);
        wait_idle();
        check(n_upd, 40);
        check(seen[5], calc(14'h2A55));
        check(seen[6],
            calc(14'h0400, dac_host_pkg::GAIN_RST, 14'h2100));
        check(seen[7], calc(dac_host_pkg::DATA_RST, 14'h2000));
        check(seen[39], calc(dac_host_pkg::DATA_RST));
        n_upd = 0;
        pulse_low(0);
        tick(2);
        wr_par(6'h05, dac_host_pkg::CLASS_DATA, 14'h0155, 1'b0);
        pulse_low(0);
        wait_idle();
        check(n_upd, 80);
        check(seen[5], calc(14'h0155));
        tog <= 1'b1;
        wr_par(6'h03, dac_host_pkg::CLASS_DATA, 14'h0100, 1'b0);
        wr_par(6'h03, dac_host_pkg::CLASS_DATA, 14'h0200, 1'b1);
        pulse_low(0);
        wait_idle();
        va = seen[3];
        pulse_low(0);
        wait_idle();
        check({va, seen[3]} == {calc(14'h0100), calc(14'h0200)} ||
            {va, seen[3]} == {calc(14'h0200), calc(14'h0100)}, 1'b1);
        tog <= 1'b0;
        wr_par(6'h04, dac_host_pkg::CLASS_DATA, 14'h0300, 1'b1);
        pulse_low(0);
        wait_idle();
        check(seen[4], calc(14'h0300));
        check(seen[3], calc(14'h0100));
        n_upd = 0;
        n_low = 0;
        pulse_low(1);
        wait_idle();
        check(n_upd, 40);
        check(seen[39], 16'h1234);
        check(n_low >= dac_host_pkg::CLEAR_CYCLES &&
            n_low <= dac_host_pkg::CLEAR_CYCLES + 2, 1'b1);
        pulse_low(2);
        tick(2);
        check(busy_n, 1'b0);
        n_upd = 0;
        pulse_low(0);
        wr_par(6'h05, dac_host_pkg::CLASS_DATA, 14'h0777, 1'b0);
        wait_idle();
        tick(60);
        check(n_upd, 0);
        pulse_low(0);
        wait_idle();
        check(seen[5], calc(dac_host_pkg::DATA_RST));
        sel <= 1'b1;
        chain <= 1'b1;
        tick(6);
        check(oe, 1'b1);
        frame <= 1'b1;
        tick(140);
        check(rx_cnt, 16);
        // Second frame reads back the first frame's first eight bits, 24 clocks late
        frame <= 1'b0;
        tick(2);
        frame <= 1'b1;
        tick(140);
        check(rx_cnt, 16);
        check(rx_dat, 16'h00AA);
        cs_n <= 1'b1;
        tick(6);
        check(oe, 1'b0);
        print_verdict();
    end
endmodule
